// ### rtl/axis_regs_pkg.sv
// constants, register map and carrier types for the axis status and mode register bank
package axis_regs_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_AXES = 4; // axis code is two bits wide
  localparam int AXW = 2; // width of the axis code
  localparam int ADDR_W = 8; // byte address bits decoded

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00; // status word of the selected axis
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04; // mode word of the selected axis
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h08; // command strobe register
  localparam logic [ADDR_W-1:0] OFS_SEL = 8'h0C; // selected axis

  // ----------------------------------------------------------------
  // status word field positions
  // ----------------------------------------------------------------
  localparam int ST_DONE = 0; // motion complete
  localparam int ST_ALARM = 1; // drive alarm
  localparam int ST_BRK = 2; // breakpoint reached
  localparam int ST_CAPT = 3; // index or home captured
  localparam int ST_ERR = 4; // following error over band
  localparam int ST_PLIM = 5; // positive limit
  localparam int ST_NLIM = 6; // negative limit
  localparam int ST_CMDERR = 7; // command rejected
  localparam int NUM_EVT = 8; // sticky event bits 0..7
  localparam int NUM_IRQ_EVT = 7; // event bits 0..6 may request attention

  // ----------------------------------------------------------------
  // mode word field positions and motion codes
  // ----------------------------------------------------------------
  localparam int MD_AUTOHALT = 7; // halt and drive off on error over band
  localparam int MD_SELFUPD = 10; // load pending parameters at breakpoint
  localparam int MD_CODE_LO = 11; // motion code low bit
  localparam int MD_CODE_HI = 13; // motion code high bit

  typedef enum logic [2:0] {
    MM_TRAP = 3'h0, // trapezoid positioning
    MM_JOG = 3'h1, // independent jogging
    MM_SCURVE = 3'h2, // s-curve positioning
    MM_GEAR = 3'h3, // electronic gearing
    MM_COORD = 3'h5 // coordinated motion
  } motion_mode_t;

  // ----------------------------------------------------------------
  // command register layout and opcodes
  // ----------------------------------------------------------------
  localparam int CMD_OP_LO = 0; // opcode low bit
  localparam int CMD_OP_HI = 3; // opcode high bit
  localparam int CMD_MASK_LO = 8; // clear mask low bit
  localparam int CMD_MASK_HI = 15; // clear mask high bit

  typedef enum logic [3:0] {
    OP_CLEAR_ALL = 4'h1, // clear_all_events_cmd
    OP_CLEAR_SEL = 4'h2, // clear_selected_events_cmd
    OP_SMOOTH_STOP = 4'h3, // smooth_stop_cmd
    OP_ABRUPT_STOP = 4'h4, // abrupt_stop_cmd
    OP_DRIVE_EN = 4'h5, // drive_enable_cmd
    OP_HALT_EN = 4'h6, // auto_halt_enable_cmd
    OP_HALT_DIS = 4'h7, // auto_halt_disable_cmd
    OP_UPD_EN = 4'h8, // self_update_enable_cmd
    OP_UPD_DIS = 4'h9 // self_update_disable_cmd
  } cmd_op_t;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic targetReached; // profile reached its target, pulse
    logic actVelZero; // actual velocity is zero, level
    logic cmdVelZero; // commanded velocity is zero, level
    logic driveAlarm; // drive alarm, level
    logic bpHit; // breakpoint condition met, pulse
    logic captureHit; // armed capture event seen, pulse
    logic errOver; // following error beyond band, level
    logic posLimit; // positive limit triggered, level
    logic negLimit; // negative limit triggered, level
    logic loopClosed; // servo loop closed
    logic driveOn; // drive enabled
    logic profMoving; // trajectory generator moving
    logic limitMonEn; // limit monitoring enabled
    logic homeArmed; // home capture armed
    logic indexArmed; // index capture armed
  } axis_in_t;

  typedef struct packed {
    logic haltReq; // stop the profile at once, pulse
    logic smoothStopReq; // start a smooth stop, pulse
    logic driveOffReq; // disable the drive, pulse
    logic driveOnReq; // enable the drive, pulse
    logic loadPendingReq; // load pending parameters, pulse
    logic eventIrq; // an attention event bit was newly set, pulse
  } axis_out_t;

  typedef struct packed {
    logic [NUM_EVT-1:0] evt; // sticky event bits
    logic autoHalt; // mode bit 7
    logic selfUpd; // mode bit 10
    logic [2:0] mcode; // mode bits 13:11
    logic smoothPend; // smooth stop waiting for zero velocity
  } axis_state_t;

endpackage : axis_regs_pkg

// ### rtl/axis_status_and_mode_regs.sv
// per-axis status and mode register bank behind an AXI4-Lite slave
//
// How it works
// RULE1 - one 16-bit status word per axis
// RULE2 - bit0 set on completion, ignored when gearing
// RULE3 - bit1 set on drive alarm
// RULE4 - bit2 set when breakpoint condition met
// RULE5 - bit3 set on armed capture event
// RULE6 - bit4 error flag; clear only outside error
// RULE7 - bit5 positive limit, bit6 negative limit
// RULE8 - bit7 set when last command rejected
// RULE9 - bits 8,9,11 live loop, drive, limit monitor
// RULE10 - bit10 in motion, read only, no attention
// RULE11 - bits 13:12 selected axis code
// RULE12 - bit14 home armed, bit15 index armed
// RULE13 - bits 8..15 unaffected by clears
// RULE14 - event bits sticky until clear commands
// RULE15 - bits 0..6 may request host attention
// RULE16 - host clears completion flag promptly
// RULE17 - list of completion causes sets bit0
// RULE18 - motion flags follow the trajectory generator
// RULE19 - gearing mode holds in-motion at one
// RULE20 - mode bit7 halts axis on error overrun
// RULE21 - mode bit10 loads parameters at breakpoint
// RULE22 - mode bits 13:11 motion code, 000 trapezoid
// RULE23 - other codes 001,010,011,101; bits 14,15 reserved
// RULE24 - reserved mode bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none

module axis_status_and_mode_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [axis_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [axis_regs_pkg::ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // motion core side
  input wire axis_regs_pkg::axis_in_t [axis_regs_pkg::NUM_AXES-1:0] axisIn,
  output axis_regs_pkg::axis_out_t [axis_regs_pkg::NUM_AXES-1:0] axisOut
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    axis_regs_pkg::axis_state_t [axis_regs_pkg::NUM_AXES-1:0] ax; // per-axis registers
    logic [axis_regs_pkg::AXW-1:0] sel; // selected axis
    logic awHeld; // write address captured
    logic [axis_regs_pkg::ADDR_W-1:0] awAddr; // captured write address
    logic wHeld; // write data captured
    logic [31:0] wData; // captured write data
    logic [3:0] wStrb; // captured byte strobes
    logic bValid; // write response pending
    logic [1:0] bResp; // write response code
    logic rValid; // read data pending
    logic [31:0] rData; // read data
    logic [1:0] rResp; // read response code
    axis_regs_pkg::axis_out_t [axis_regs_pkg::NUM_AXES-1:0] out; // registered requests
  } regs_t;

  regs_t st_r; // registered state
  regs_t st_nxt; // next state

  // ----------------------------------------------------------------
  // handshake outputs
  // ----------------------------------------------------------------
  // a write channel is ready while its holding slot is free and no response waits; read address is ready while no read data waits
  assign s_axi_awready = !st_r.awHeld && !st_r.bValid;
  assign s_axi_wready = !st_r.wHeld && !st_r.bValid;
  assign s_axi_arready = !st_r.rValid;
  assign s_axi_bvalid = st_r.bValid;
  assign s_axi_bresp = st_r.bResp;
  assign s_axi_rvalid = st_r.rValid;
  assign s_axi_rdata = st_r.rData;
  assign s_axi_rresp = st_r.rResp;
  assign axisOut = st_r.out;

  // ----------------------------------------------------------------
  // status word of one axis
  // ----------------------------------------------------------------
  function automatic logic [15:0] status_word(
    input axis_regs_pkg::axis_state_t s,
    input axis_regs_pkg::axis_in_t i,
    input logic [axis_regs_pkg::AXW-1:0] code
  );
    logic gear;
    gear = (s.mcode == axis_regs_pkg::MM_GEAR);
    // live bits come straight from the trajectory side, not the encoder
    status_word = {i.indexArmed, i.homeArmed, // see RULE12
                   code, // see RULE11
                   i.limitMonEn, // see RULE9
                   i.profMoving | gear, // see RULE10 see RULE18 see RULE19
                   i.driveOn, i.loopClosed, // see RULE9
                   s.evt}; // see RULE1
  endfunction : status_word

  // ----------------------------------------------------------------
  // mode word of one axis
  // ----------------------------------------------------------------
  function automatic logic [15:0] mode_word(input axis_regs_pkg::axis_state_t s);
    mode_word = 16'h0000; // reserved bits read zero, see RULE24 see RULE23
    mode_word[axis_regs_pkg::MD_AUTOHALT] = s.autoHalt;
    mode_word[axis_regs_pkg::MD_SELFUPD] = s.selfUpd;
    mode_word[axis_regs_pkg::MD_CODE_HI:axis_regs_pkg::MD_CODE_LO] = s.mcode; // see RULE22
  endfunction : mode_word

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic doWrite; // both halves of a write are present
    logic [axis_regs_pkg::ADDR_W-1:0] wa; // effective write address
    logic [31:0] wd; // effective write data
    logic [3:0] ws; // effective strobes
    logic cmdValid; // command write accepted
    logic cmdBad; // command write rejected
    logic [3:0] op; // command opcode
    logic [axis_regs_pkg::NUM_EVT-1:0] clrMask; // event bits cleared this cycle
    logic [axis_regs_pkg::NUM_EVT-1:0] setMask; // event bits set this cycle
    logic [2:0] newCode; // mode code written
    logic doneCause; // any completion cause
    logic gear; // axis in gearing mode
    logic jog; // axis in jogging mode
    logic errHalt; // auto halt firing
    logic isSel; // this axis is the selected one
    doWrite = 1'b0;
    wa = '0;
    wd = '0;
    ws = '0;
    cmdValid = 1'b0;
    cmdBad = 1'b0;
    op = '0;
    newCode = '0;
    clrMask = '0;
    setMask = '0;
    doneCause = 1'b0;
    gear = 1'b0;
    jog = 1'b0;
    errHalt = 1'b0;
    isSel = 1'b0;
    st_nxt = st_r;

    // pulses last one cycle
    st_nxt.out = '0;

    // write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    // the write acts once both halves are held
    if (st_r.awHeld && st_r.wHeld) begin
      doWrite = 1'b1;
      wa = st_r.awAddr;
      wd = st_r.wData;
      ws = st_r.wStrb;
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp = axis_regs_pkg::RESP_OKAY;
    end
    // response retires when the master takes it
    if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end

    // decode the write
    if (doWrite) begin
      unique case ({wa[axis_regs_pkg::ADDR_W-1:2], 2'h0})
        axis_regs_pkg::OFS_STATUS: begin
          // status word is not writable by software
        end
        axis_regs_pkg::OFS_MODE: begin
          // only the motion code is writable
          if (ws[1]) begin
            newCode = wd[axis_regs_pkg::MD_CODE_HI:axis_regs_pkg::MD_CODE_LO];
            unique case (newCode)
              axis_regs_pkg::MM_TRAP, axis_regs_pkg::MM_JOG, axis_regs_pkg::MM_SCURVE,
              axis_regs_pkg::MM_GEAR, axis_regs_pkg::MM_COORD: begin
                st_nxt.ax[st_r.sel].mcode = newCode; // see RULE22 see RULE23
                cmdValid = 1'b1;
              end
              default: begin
                cmdBad = 1'b1; // undefined motion code, see RULE8
              end
            endcase
          end
        end
        axis_regs_pkg::OFS_CMD: begin
          if (ws[0]) begin
            op = wd[axis_regs_pkg::CMD_OP_HI:axis_regs_pkg::CMD_OP_LO];
            unique case (op)
              axis_regs_pkg::OP_CLEAR_ALL, axis_regs_pkg::OP_CLEAR_SEL, axis_regs_pkg::OP_SMOOTH_STOP,
              axis_regs_pkg::OP_ABRUPT_STOP, axis_regs_pkg::OP_DRIVE_EN, axis_regs_pkg::OP_HALT_EN,
              axis_regs_pkg::OP_HALT_DIS, axis_regs_pkg::OP_UPD_EN, axis_regs_pkg::OP_UPD_DIS: begin
                cmdValid = 1'b1;
              end
              default: begin
                cmdBad = 1'b1; // unknown opcode, see RULE8
              end
            endcase
          end
        end
        axis_regs_pkg::OFS_SEL: begin
          if (ws[0]) begin
            st_nxt.sel = wd[axis_regs_pkg::AXW-1:0];
          end
        end
        default: begin
          st_nxt.bResp = axis_regs_pkg::RESP_DECERR; // unmapped address
        end
      endcase
    end

    // per-axis event and mode logic
    for (int a = 0; a < axis_regs_pkg::NUM_AXES; a++) begin
      isSel = (st_r.sel == a[axis_regs_pkg::AXW-1:0]);
      gear = (st_r.ax[a].mcode == axis_regs_pkg::MM_GEAR);
      jog = (st_r.ax[a].mcode == axis_regs_pkg::MM_JOG);
      errHalt = st_r.ax[a].autoHalt && axisIn[a].errOver; // see RULE20
      clrMask = '0;
      setMask = '0;

      // commands act on the selected axis
      if (isSel && cmdValid && op != 4'h0) begin
        unique case (op)
          axis_regs_pkg::OP_CLEAR_ALL: clrMask = '1; // see RULE14
          axis_regs_pkg::OP_CLEAR_SEL: clrMask = wd[axis_regs_pkg::CMD_MASK_HI:axis_regs_pkg::CMD_MASK_LO]; // see RULE14
          axis_regs_pkg::OP_SMOOTH_STOP: begin
            st_nxt.ax[a].smoothPend = 1'b1;
            st_nxt.out[a].smoothStopReq = 1'b1;
          end
          axis_regs_pkg::OP_ABRUPT_STOP: st_nxt.out[a].haltReq = 1'b1;
          axis_regs_pkg::OP_DRIVE_EN: st_nxt.out[a].driveOnReq = 1'b1;
          axis_regs_pkg::OP_HALT_EN: st_nxt.ax[a].autoHalt = 1'b1; // see RULE20
          axis_regs_pkg::OP_HALT_DIS: st_nxt.ax[a].autoHalt = 1'b0; // see RULE20
          axis_regs_pkg::OP_UPD_EN: st_nxt.ax[a].selfUpd = 1'b1; // see RULE21
          axis_regs_pkg::OP_UPD_DIS: st_nxt.ax[a].selfUpd = 1'b0; // see RULE21
          default: begin
          end
        endcase
      end
      // error flag survives a clear while the error persists
      if (axisIn[a].errOver) begin
        clrMask[axis_regs_pkg::ST_ERR] = 1'b0; // see RULE6
      end

      // smooth stop completes when actual velocity reaches zero
      doneCause = 1'b0;
      if (st_r.ax[a].smoothPend && axisIn[a].actVelZero) begin
        st_nxt.ax[a].smoothPend = 1'b0;
        doneCause = 1'b1;
      end
      // completion causes
      doneCause = doneCause | axisIn[a].targetReached // see RULE17 see RULE18
                | (jog && axisIn[a].actVelZero && axisIn[a].cmdVelZero)
                | (isSel && cmdValid && (op == axis_regs_pkg::OP_ABRUPT_STOP || op == axis_regs_pkg::OP_DRIVE_EN))
                | (axisIn[a].limitMonEn && (axisIn[a].posLimit || axisIn[a].negLimit))
                | errHalt | axisIn[a].driveAlarm;
      setMask[axis_regs_pkg::ST_DONE] = doneCause && !gear; // see RULE2
      setMask[axis_regs_pkg::ST_ALARM] = axisIn[a].driveAlarm; // see RULE3
      setMask[axis_regs_pkg::ST_BRK] = axisIn[a].bpHit; // see RULE4
      setMask[axis_regs_pkg::ST_CAPT] = axisIn[a].captureHit; // see RULE5
      setMask[axis_regs_pkg::ST_ERR] = axisIn[a].errOver; // see RULE6
      setMask[axis_regs_pkg::ST_PLIM] = axisIn[a].posLimit; // see RULE7
      setMask[axis_regs_pkg::ST_NLIM] = axisIn[a].negLimit; // see RULE7
      setMask[axis_regs_pkg::ST_CMDERR] = isSel && cmdBad; // see RULE8

      // set wins over clear in the same cycle
      st_nxt.ax[a].evt = (st_r.ax[a].evt & ~clrMask) | setMask; // see RULE14

      // attention pulse when one of bits 0..6 rises
      st_nxt.out[a].eventIrq = |(setMask[axis_regs_pkg::NUM_IRQ_EVT-1:0]
                               & ~st_r.ax[a].evt[axis_regs_pkg::NUM_IRQ_EVT-1:0]); // see RULE15

      // auto halt stops the profile and drops the drive
      if (errHalt) begin
        st_nxt.out[a].haltReq = 1'b1; // see RULE20
        st_nxt.out[a].driveOffReq = 1'b1; // see RULE20
      end
      // self update loads pending parameters at the breakpoint
      st_nxt.out[a].loadPendingReq = st_r.ax[a].selfUpd && axisIn[a].bpHit; // see RULE21
    end

    // read path, one cycle after the address is taken
    if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rValid) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp = axis_regs_pkg::RESP_OKAY;
      st_nxt.rData = 32'h0000_0000;
      unique case ({s_axi_araddr[axis_regs_pkg::ADDR_W-1:2], 2'h0})
        axis_regs_pkg::OFS_STATUS:
          st_nxt.rData[15:0] = status_word(st_r.ax[st_r.sel], axisIn[st_r.sel], st_r.sel); // see RULE13
        axis_regs_pkg::OFS_MODE: st_nxt.rData[15:0] = mode_word(st_r.ax[st_r.sel]);
        axis_regs_pkg::OFS_CMD: st_nxt.rData = 32'h0000_0000; // strobe register reads zero
        axis_regs_pkg::OFS_SEL: st_nxt.rData[axis_regs_pkg::AXW-1:0] = st_r.sel;
        default: st_nxt.rResp = axis_regs_pkg::RESP_DECERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

endmodule : axis_status_and_mode_regs

`default_nettype wire

// ### verification/axis_regs_properties.sv
// port checks for the axis register bank
`timescale 1ns/1ps
`default_nettype none
module axis_regs_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire axis_regs_pkg::axis_in_t [axis_regs_pkg::NUM_AXES-1:0] axisIn,
  input wire axis_regs_pkg::axis_out_t [axis_regs_pkg::NUM_AXES-1:0] axisOut
);
  // one domain; reset cancels every check
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // address and data taken at the same edge
  sequence s_wr_taken;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence s_rd_taken;
    ce && s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken ##1 ce |=> s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid) else $error("read data late");
  a_bresp_holds: assert property (ce && s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (ce && s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_readies_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
  a_word_sixteen: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_halt_drive_off: assert property (axisOut[0].driveOffReq |-> axisOut[0].haltReq && $past(axisIn[0].errOver))
    else $error("drive off without halt");
  a_load_pending: assert property (axisOut[0].loadPendingReq |-> $past(axisIn[0].bpHit))
    else $error("load without breakpoint");
endmodule : axis_regs_properties
bind axis_status_and_mode_regs axis_regs_properties i_axis_regs_properties (.*);
`default_nettype wire

// ### verification/bus_host.sv
// host model, an axi4-lite master
`timescale 1ns/1ps
`default_nettype none
module bus_host (
  input wire logic mclk,
  output logic awValid,
  input wire logic awReady,
  output logic [7:0] awAddr,
  output logic wValid,
  input wire logic wReady,
  output logic [31:0] wData,
  output logic [3:0] wStrb,
  input wire logic bValid,
  output logic bReady,
  input wire logic [1:0] bResp,
  output logic arValid,
  input wire logic arReady,
  output logic [7:0] arAddr,
  input wire logic rValid,
  output logic rReady,
  input wire logic [31:0] rData,
  input wire logic [1:0] rResp
);
  // bus idle; answer readies always high
  initial begin
    {awValid, wValid, arValid} = 3'h0;
    {bReady, rReady} = 2'h3;
    {awAddr, arAddr, wData, wStrb} = 52'h0;
  end
  // one write; each channel dropped at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] resp);
    logic ga, gw, gb;
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    do begin
      @(negedge mclk);
      ga = awValid && awReady;
      gw = wValid && wReady;
      gb = bValid;
      resp = bResp;
      @(posedge mclk);
      if (ga) awValid <= 1'b0;
      if (gw) wValid <= 1'b0;
    end while (!gb);
  endtask : wr
  // one read; data taken at its handshake edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ga, gb;
    arAddr <= a;
    arValid <= 1'b1;
    do begin
      @(negedge mclk);
      ga = arValid && arReady;
      gb = rValid;
      d = rData;
      resp = rResp;
      @(posedge mclk);
      if (ga) arValid <= 1'b0;
    end while (!gb);
  endtask : rd
endmodule : bus_host
`default_nettype wire

// ### verification/axis_status_and_mode_regs_test.sv
// self-checking bench for the axis register bank
`timescale 1ns/1ps
`default_nettype none
module axis_status_and_mode_regs_test;
  logic mclk, rst, ce; // clock, reset, run enable
  logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady; // handshakes
  logic [7:0] awAddr, arAddr; // byte addresses
  logic [31:0] wData, rData, rdVal; // bus data, last read
  logic [3:0] wStrb; // byte lanes
  logic [1:0] bResp, rResp, rsp; // responses, last seen
  axis_regs_pkg::axis_in_t [3:0] ain; // motion core state
  axis_regs_pkg::axis_out_t [3:0] aout; // requests to the core
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5}; // legal motion codes
  int nFail, samplesChecked, cycles; // counters
  axis_status_and_mode_regs i_axis_status_and_mode_regs (.mclk(mclk), .rst(rst), .ce(ce),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_araddr(arAddr), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .axisIn(ain), .axisOut(aout));
  bus_host i_bus_host (.*);
  // 100 ns clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      report_and_stop();
    end
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // counts, verdict, end
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // one-cycle input pulse
  task automatic pulse(input int ax, input int b);
    @(posedge mclk);
    ain[ax][b] <= 1'b1;
    @(posedge mclk);
    ain[ax][b] <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : pulse
  // register shorthands
  task automatic sts(input logic [15:0] e);
    i_bus_host.rd(axis_regs_pkg::OFS_STATUS, rdVal, rsp);
    chk(rdVal, {16'h0000, e});
  endtask : sts
  task automatic md(input logic [15:0] e);
    i_bus_host.rd(axis_regs_pkg::OFS_MODE, rdVal, rsp);
    chk(rdVal, {16'h0000, e});
  endtask : md
  task automatic cmd(input logic [15:0] w);
    i_bus_host.wr(axis_regs_pkg::OFS_CMD, {16'h0000, w}, 4'h3, rsp);
  endtask : cmd
  task automatic mw(input logic [31:0] w);
    i_bus_host.wr(axis_regs_pkg::OFS_MODE, w, 4'h2, rsp);
  endtask : mw
  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    ain = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    sts(16'h0000);
    md(16'h0000);
    // event bits 0..6 in turn, sticky, then cleared
    for (int i = 0; i < 7; i++) begin
      pulse(0, (i == 0) ? 14 : 12 - i);
      sts((16'h0001 << i) | ((i == 1) ? 16'h0001 : 16'h0000));
      cmd(16'h0001);
      sts(16'h0000);
    end
    ain[0].errOver <= 1'b1;
    pulse(0, 10);
    pulse(0, 9);
    cmd(16'h1C02);
    sts(16'h0010);
    ain[0].errOver <= 1'b0;
    cmd(16'h1002);
    sts(16'h0000);
    $display("test event bits done");
    // abrupt, drive enable and smooth stop
    for (int k = 4; k < 6; k++) begin
      cmd(16'(k));
      sts(16'h0001);
      cmd(16'h0001);
    end
    cmd(16'h0003);
    sts(16'h0000);
    ain[0].actVelZero <= 1'b1;
    repeat (3) @(posedge mclk);
    sts(16'h0001);
    ain[0].actVelZero <= 1'b0;
    cmd(16'h0001);
    $display("test completion causes done");
    // codes, reserved bits, rejected code and opcode
    foreach (codes[k]) begin
      mw({18'h00000, codes[k], 11'h000});
      md({2'h0, codes[k], 11'h000});
    end
    mw(32'h0000C7FF);
    md(16'h0000);
    mw(32'h00003800);
    md(16'h0000);
    sts(16'h0080);
    cmd(16'h0001);
    cmd(16'h000F);
    sts(16'h0080);
    cmd(16'h0001);
    mw(32'h00001800);
    pulse(0, 14);
    sts(16'h0400);
    mw(32'h00000000);
    $display("test mode word done");
    // auto-halt and self-update flags
    cmd(16'h0006);
    md(16'h0080);
    pulse(0, 8);
    sts(16'h0011);
    cmd(16'h0007);
    cmd(16'h0008);
    md(16'h0400);
    pulse(0, 10);
    cmd(16'h0009);
    md(16'h0000);
    cmd(16'h0001);
    $display("test mode commands done");
    // axis 2 live bits, immune to clears
    i_bus_host.wr(axis_regs_pkg::OFS_SEL, 32'h00000002, 4'h1, rsp);
    ain[2][5:0] <= 6'h3F;
    repeat (2) @(posedge mclk);
    sts(16'hEF00);
    i_bus_host.wr(axis_regs_pkg::OFS_STATUS, 32'h0000FFFF, 4'hF, rsp);
    cmd(16'hFF02);
    sts(16'hEF00);
    $display("test live bits done");
    // unmapped place
    i_bus_host.wr(8'h10, 32'h00000001, 4'hF, rsp);
    chk({30'h0, rsp}, {30'h0, axis_regs_pkg::RESP_DECERR});
    i_bus_host.rd(8'h10, rdVal, rsp);
    chk({rdVal[31:2], rsp}, {30'h0, axis_regs_pkg::RESP_DECERR});
    $display("test unmapped done");
    report_and_stop();
  end
endmodule : axis_status_and_mode_regs_test
`default_nettype wire
